//--- verilog/crs_defs.vh
// Notes on behaviour
// - two 8-bit index registers; the second is never stacked on interrupt entry or return
// - program counter is 16 bits, low and high byte, holds next instruction address
// - after reset the program counter loads from the two-byte vector at top of map
// - flag register is 8 bits, top three read one, mask comes out of reset set
// - flag register pushes and pops whole; only carry and mask have their own set and clear, and bit test writes carry
// - half carry is set on carry from bit 3 to 4 in add and add-with-carry only
// - mask bit 3 set on entry or by software, cleared by software or return
// - requests arriving while masked stay pending and are taken once mask clears
// - clearing the mask inside a service routine lets pending requests in at once
// - negative flag copies the top bit of the last result
// - zero flag is set when the last result is zero, cleared otherwise
// - carry set on overflow or borrow; also bit test, shift, rotate, set and clear
// - stack pointer is 16 bits with upper ten bits fixed, 64-byte stack area
// - stack pointer marks next free byte; decrement after push, increment before pop
// - reset and the stack reinit instruction load the stack top address
// - stack pointer wraps at both limits silently, old contents overwritten
// - stack pointer low six bits are written directly by a load
// - interrupt entry writes program counter low first at the stack pointer, then downward
// - a call stacks two bytes, an interrupt five
`ifndef CRS_DEFS_VH
`define CRS_DEFS_VH

`define CRS_RESET_VECTOR 16'hFFFE
`define CRS_SP_RESET 16'h017F
`define CRS_SP_FIXED 10'h005

`define CRS_CC_C 0
`define CRS_CC_Z 1
`define CRS_CC_N 2
`define CRS_CC_I 3
`define CRS_CC_H 4
`define CRS_CC_ONES 3'h7

`define CRS_OP_NOP 5'h00
`define CRS_OP_LD_A 5'h01
`define CRS_OP_LD_X 5'h02
`define CRS_OP_LD_Y 5'h03
`define CRS_OP_ADD 5'h04
`define CRS_OP_ADC 5'h05
`define CRS_OP_SUB 5'h06
`define CRS_OP_AND 5'h07
`define CRS_OP_SHL 5'h08
`define CRS_OP_RLC 5'h09
`define CRS_OP_BTJ 5'h0A
`define CRS_OP_SCF 5'h0B
`define CRS_OP_RCF 5'h0C
`define CRS_OP_SIM 5'h0D
`define CRS_OP_RIM 5'h0E
`define CRS_OP_LD_S 5'h0F
`define CRS_OP_RSP 5'h10
`define CRS_OP_PUSH_A 5'h11
`define CRS_OP_PUSH_CC 5'h12
`define CRS_OP_POP_A 5'h13
`define CRS_OP_POP_CC 5'h14
`define CRS_OP_CALL 5'h15
`define CRS_OP_RET 5'h16
`define CRS_OP_TRAP 5'h17
`define CRS_OP_RETURN_FROM_INTERRUPT 5'h18
`define CRS_OP_JUMP 5'h19
`define CRS_OP_PC_ADV 5'h1A

`define CRS_K_VEC 4'h0
`define CRS_K_INT 4'h1
`define CRS_K_CALL 4'h2
`define CRS_K_PUSH_A 4'h3
`define CRS_K_PUSH_CC 4'h4
`define CRS_K_RETURN_FROM_INTERRUPT 4'h5
`define CRS_K_RET 4'h6
`define CRS_K_POP_A 4'h7
`define CRS_K_POP_CC 4'h8

`define CRS_T_NONE 3'h0
`define CRS_T_PCL 3'h1
`define CRS_T_PCH 3'h2
`define CRS_T_X 3'h3
`define CRS_T_A 3'h4
`define CRS_T_CC 3'h5

`endif

//--- verilog/crs_core_regs.v
`include "crs_defs.vh"
`default_nettype none

module crs_core_regs (
  input wire sys_clk,
  input wire rst_b,
  input wire op_valid,
  input wire [4:0] op_code,
  input wire [7:0] op_data,
  input wire [2:0] op_bit,
  input wire [15:0] op_addr,
  input wire irq_req,
  input wire [15:0] irq_vector,
  input wire [7:0] mem_rdata,
  output reg busy,
  output reg [7:0] acc,
  output reg [7:0] idx_x,
  output reg [7:0] idx_y,
  output reg [15:0] pc,
  output reg [7:0] condition_flags,
  output reg [15:0] stack_pointer,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_we,
  output reg mem_re,
  output reg irq_ack
);

  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_PUSH = 2'b01;
  localparam [1:0] S_READ = 2'b10;
  localparam [1:0] S_DRAIN = 2'b11;

  reg [1:0] state;
  reg [3:0] kind;
  reg [2:0] step;
  reg [15:0] target;
  reg [2:0] rd_tag;
  reg [2:0] rd_tag_d1;
  reg irq_pend;

  reg [7:0] alu_res;
  reg alu_c;
  reg alu_h;
  reg [8:0] wide;
  reg [4:0] half;
  reg cin;

  wire take_irq;
  wire [5:0] sp_low;
  wire [5:0] sp_dec;
  wire [5:0] sp_inc;
  wire last_step;
  wire [2:0] cur_tag;

  function [2:0] seq_len;
    input [3:0] k;
    begin
      case (k)
        `CRS_K_VEC: seq_len = 3'h2;
        `CRS_K_INT: seq_len = 3'h5;
        `CRS_K_CALL: seq_len = 3'h2;
        `CRS_K_RETURN_FROM_INTERRUPT: seq_len = 3'h5;
        `CRS_K_RET: seq_len = 3'h2;
        default: seq_len = 3'h1;
      endcase
    end
  endfunction

  function [2:0] seq_tag;
    input [3:0] k;
    input [2:0] s;
    begin
      seq_tag = `CRS_T_NONE;
      case (k)
        `CRS_K_VEC: begin
          seq_tag = (s == 3'h0) ? `CRS_T_PCH : `CRS_T_PCL;
        end
        `CRS_K_INT: begin
          // index y never appears here
          case (s)
            3'h0: seq_tag = `CRS_T_PCL;
            3'h1: seq_tag = `CRS_T_PCH;
            3'h2: seq_tag = `CRS_T_X;
            3'h3: seq_tag = `CRS_T_A;
            default: seq_tag = `CRS_T_CC;
          endcase
        end
        `CRS_K_CALL: begin
          seq_tag = (s == 3'h0) ? `CRS_T_PCL : `CRS_T_PCH;
        end
        `CRS_K_PUSH_A: begin
          seq_tag = `CRS_T_A;
        end
        `CRS_K_PUSH_CC: begin
          seq_tag = `CRS_T_CC;
        end
        `CRS_K_RETURN_FROM_INTERRUPT: begin
          // exact reverse of entry
          case (s)
            3'h0: seq_tag = `CRS_T_CC;
            3'h1: seq_tag = `CRS_T_A;
            3'h2: seq_tag = `CRS_T_X;
            3'h3: seq_tag = `CRS_T_PCH;
            default: seq_tag = `CRS_T_PCL;
          endcase
        end
        `CRS_K_RET: begin
          seq_tag = (s == 3'h0) ? `CRS_T_PCH : `CRS_T_PCL;
        end
        `CRS_K_POP_A: begin
          seq_tag = `CRS_T_A;
        end
        `CRS_K_POP_CC: begin
          seq_tag = `CRS_T_CC;
        end
        default: begin
          seq_tag = `CRS_T_NONE;
        end
      endcase
    end
  endfunction

  // only six low bits move, so both limits wrap with no flag
  assign sp_low = stack_pointer[5:0];
  assign sp_dec = sp_low - 6'h01;
  assign sp_inc = sp_low + 6'h01;
  assign last_step = (step == (seq_len(kind) - 3'h1));
  assign cur_tag = seq_tag(kind, step);

  // ops win the idle slot; the request is taken in the next free one
  assign take_irq = (state == S_IDLE) && !op_valid && irq_pend &&
                    !condition_flags[`CRS_CC_I];

  always @* begin
    cin = 1'b0;
    wide = 9'h000;
    half = 5'h00;
    alu_res = acc;
    alu_c = condition_flags[`CRS_CC_C];
    alu_h = condition_flags[`CRS_CC_H];
    case (op_code)
      `CRS_OP_ADD, `CRS_OP_ADC: begin
        cin = (op_code == `CRS_OP_ADC) ? condition_flags[`CRS_CC_C] : 1'b0;
        wide = {1'b0, acc} + {1'b0, op_data} + {8'h00, cin};
        half = {1'b0, acc[3:0]} + {1'b0, op_data[3:0]} + {4'h0, cin};
        alu_res = wide[7:0];
        alu_c = wide[8];
        alu_h = half[4];
      end
      `CRS_OP_SUB: begin
        wide = {1'b0, acc} - {1'b0, op_data};
        alu_res = wide[7:0];
        alu_c = wide[8];
      end
      `CRS_OP_AND: begin
        alu_res = acc & op_data;
      end
      `CRS_OP_SHL: begin
        alu_res = {acc[6:0], 1'b0};
        alu_c = acc[7];
      end
      `CRS_OP_RLC: begin
        alu_res = {acc[6:0], condition_flags[`CRS_CC_C]};
        alu_c = acc[7];
      end
      default: begin
        alu_res = op_data;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= S_READ;
      kind <= `CRS_K_VEC;
      step <= 3'h0;
      busy <= 1'b1;
      target <= 16'h0000;
      rd_tag <= `CRS_T_NONE;
      rd_tag_d1 <= `CRS_T_NONE;
      irq_pend <= 1'b0;
      acc <= 8'h00;
      idx_x <= 8'h00;
      idx_y <= 8'h00;
      pc <= 16'h0000;
      condition_flags <= {`CRS_CC_ONES, 5'h08};
      stack_pointer <= `CRS_SP_RESET;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      irq_ack <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      irq_ack <= 1'b0;
      rd_tag <= `CRS_T_NONE;
      rd_tag_d1 <= rd_tag;
      // a new request in the taking cycle stays pending
      irq_pend <= irq_req | (irq_pend & ~take_irq);

      case (state)
        S_IDLE: begin
          if (op_valid) begin
            case (op_code)
              `CRS_OP_LD_A, `CRS_OP_ADD, `CRS_OP_ADC, `CRS_OP_SUB, `CRS_OP_AND,
              `CRS_OP_SHL, `CRS_OP_RLC: begin
                acc <= alu_res;
                condition_flags[`CRS_CC_N] <= alu_res[7];
                condition_flags[`CRS_CC_Z] <= (alu_res == 8'h00);
                condition_flags[`CRS_CC_C] <= alu_c;
                condition_flags[`CRS_CC_H] <= alu_h;
              end
              `CRS_OP_LD_X, `CRS_OP_LD_Y: begin
                if (op_code == `CRS_OP_LD_X) begin
                  idx_x <= op_data;
                end else begin
                  idx_y <= op_data;
                end
                condition_flags[`CRS_CC_N] <= op_data[7];
                condition_flags[`CRS_CC_Z] <= (op_data == 8'h00);
              end
              `CRS_OP_BTJ: begin
                condition_flags[`CRS_CC_C] <= op_data[op_bit];
              end
              `CRS_OP_SCF: begin
                condition_flags[`CRS_CC_C] <= 1'b1;
              end
              `CRS_OP_RCF: begin
                condition_flags[`CRS_CC_C] <= 1'b0;
              end
              `CRS_OP_SIM: begin
                condition_flags[`CRS_CC_I] <= 1'b1;
              end
              `CRS_OP_RIM: begin
                condition_flags[`CRS_CC_I] <= 1'b0;
              end
              `CRS_OP_LD_S: begin
                stack_pointer <= {`CRS_SP_FIXED, op_data[5:0]};
              end
              `CRS_OP_RSP: begin
                stack_pointer <= `CRS_SP_RESET;
              end
              `CRS_OP_JUMP: begin
                pc <= op_addr;
              end
              `CRS_OP_PC_ADV: begin
                pc <= pc + {8'h00, op_data};
              end
              `CRS_OP_PUSH_A, `CRS_OP_PUSH_CC, `CRS_OP_CALL, `CRS_OP_TRAP: begin
                state <= S_PUSH;
                busy <= 1'b1;
                step <= 3'h0;
                target <= op_addr;
                if (op_code == `CRS_OP_PUSH_A) begin
                  kind <= `CRS_K_PUSH_A;
                end else if (op_code == `CRS_OP_PUSH_CC) begin
                  kind <= `CRS_K_PUSH_CC;
                end else if (op_code == `CRS_OP_CALL) begin
                  kind <= `CRS_K_CALL;
                end else begin
                  // trap ignores the mask
                  kind <= `CRS_K_INT;
                end
              end
              `CRS_OP_POP_A, `CRS_OP_POP_CC, `CRS_OP_RET, `CRS_OP_RETURN_FROM_INTERRUPT: begin
                state <= S_READ;
                busy <= 1'b1;
                step <= 3'h0;
                if (op_code == `CRS_OP_POP_A) begin
                  kind <= `CRS_K_POP_A;
                end else if (op_code == `CRS_OP_POP_CC) begin
                  kind <= `CRS_K_POP_CC;
                end else if (op_code == `CRS_OP_RET) begin
                  kind <= `CRS_K_RET;
                end else begin
                  kind <= `CRS_K_RETURN_FROM_INTERRUPT;
                end
              end
              default: begin
                state <= S_IDLE;
              end
            endcase
          end else if (take_irq) begin
            state <= S_PUSH;
            busy <= 1'b1;
            step <= 3'h0;
            kind <= `CRS_K_INT;
            target <= irq_vector;
            irq_ack <= 1'b1;
          end
        end
        S_PUSH: begin
          // write at the free byte, then step down
          mem_addr <= stack_pointer;
          mem_we <= 1'b1;
          stack_pointer <= {`CRS_SP_FIXED, sp_dec};
          case (cur_tag)
            `CRS_T_PCL: mem_wdata <= pc[7:0];
            `CRS_T_PCH: mem_wdata <= pc[15:8];
            `CRS_T_X: mem_wdata <= idx_x;
            `CRS_T_A: mem_wdata <= acc;
            default: mem_wdata <= condition_flags;
          endcase
          step <= step + 3'h1;
          if (last_step) begin
            state <= S_IDLE;
            busy <= 1'b0;
            if (kind == `CRS_K_INT) begin
              condition_flags[`CRS_CC_I] <= 1'b1;
              pc <= target;
            end else if (kind == `CRS_K_CALL) begin
              pc <= target;
            end
          end
        end
        S_READ: begin
          mem_re <= 1'b1;
          rd_tag <= cur_tag;
          if (kind == `CRS_K_VEC) begin
            mem_addr <= `CRS_RESET_VECTOR + {13'h0000, step};
          end else begin
            // step up before the read
            mem_addr <= {`CRS_SP_FIXED, sp_inc};
            stack_pointer <= {`CRS_SP_FIXED, sp_inc};
          end
          step <= step + 3'h1;
          if (last_step) begin
            state <= S_DRAIN;
          end
        end
        default: begin
          // last read data lands two edges after it was issued
          if (rd_tag == `CRS_T_NONE) begin
            state <= S_IDLE;
            busy <= 1'b0;
          end
        end
      endcase

      case (rd_tag_d1)
        `CRS_T_PCL: pc[7:0] <= mem_rdata;
        `CRS_T_PCH: pc[15:8] <= mem_rdata;
        `CRS_T_X: idx_x <= mem_rdata;
        `CRS_T_A: acc <= mem_rdata;
        `CRS_T_CC: condition_flags <= {`CRS_CC_ONES, mem_rdata[4:0]};
        default: begin
        end
      endcase
    end
  end

endmodule

`default_nettype wire

//--- testbench/crs_core_regs_properties.sv
`include "crs_defs.vh"
`default_nettype none
module crs_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire logic [4:0] op_code,
  input wire logic [7:0] op_data,
  input wire logic [2:0] op_bit,
  input wire logic [15:0] op_addr,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [7:0] mem_rdata,
  input wire logic busy,
  input wire logic [7:0] acc,
  input wire logic [7:0] idx_x,
  input wire logic [7:0] idx_y,
  input wire logic [15:0] pc,
  input wire logic [7:0] condition_flags,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic half_exp;
  wire logic go = op_valid && !busy;
  // nibble carry captured at the add edge, compared one cycle later
  always @(posedge sys_clk) half_exp <= ({1'b0, acc[3:0]} + {1'b0, op_data[3:0]}) > 5'h0F;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_top_ones: assert property (condition_flags[7:5] == 3'h7)
    else $error("flag register top bits not all one");
  a_sp_window: assert property (stack_pointer[15:6] == 10'h005)
    else $error("stack pointer left its window");
  a_reset_fetch: assert property ($rose(rst_b) |->
    (stack_pointer == 16'h017F && condition_flags[3]) ##1 (mem_re && mem_addr == 16'hFFFE)
    ##1 (mem_re && mem_addr == 16'hFFFF))
    else $error("reset state or vector fetch wrong");
  a_push_addr: assert property (mem_we |-> mem_addr[15:6] == 10'h005 &&
    mem_addr[5:0] == stack_pointer[5:0] + 6'h01)
    else $error("write not at stack pointer before decrement");
  a_pop_addr: assert property ((mem_re && mem_addr[15:8] == 8'h01) |->
    mem_addr == stack_pointer)
    else $error("read not at incremented stack pointer");
  a_irq_frame: assert property (irq_ack |-> busy ##1 (mem_we && busy) [*4]
    ##1 (mem_we && !busy && condition_flags[3]))
    else $error("interrupt entry frame wrong");
  a_irq_order: assert property (irq_ack |=> mem_wdata == pc[7:0]
    ##1 mem_wdata == pc[15:8] ##1 mem_wdata == idx_x ##1 mem_wdata == acc)
    else $error("interrupt context order wrong");
  a_masked_quiet: assert property (condition_flags[3] |=> !irq_ack)
    else $error("interrupt taken while masked");
  a_half_carry: assert property ((go && op_code == `CRS_OP_ADD) |=>
    condition_flags[4] == half_exp)
    else $error("half carry wrong after add");
  a_load_flags: assert property ((go && op_code == `CRS_OP_LD_A) |=>
    acc == $past(op_data) && condition_flags[2] == acc[7] &&
    condition_flags[1] == (acc == 8'h00))
    else $error("load result flags wrong");
endmodule
bind crs_core_regs crs_props u_props (.*);
`default_nettype wire

//--- testbench/tb_top.sv
`include "crs_defs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_b, op_valid, irq_req;
  logic re_d = 1'b0;
  logic [4:0] op_code;
  logic [7:0] op_data;
  logic [7:0] mem_rdata = 8'h00;
  logic [2:0] op_bit;
  logic [15:0] op_addr, irq_vector;
  logic [15:0] addr_d = 16'h0000;
  wire busy, mem_we, mem_re, irq_ack;
  wire [7:0] acc, idx_x, idx_y, condition_flags, mem_wdata;
  wire [15:0] pc, stack_pointer, mem_addr;
  logic [7:0] mem [0:65535];
  int fail_count, cmp_count, cyc, wrs, acks, n;
  crs_core_regs dut (.sys_clk, .rst_b, .op_valid, .op_code, .op_data, .op_bit, .op_addr,
    .irq_req, .irq_vector, .mem_rdata, .busy, .acc, .idx_x, .idx_y, .pc, .condition_flags,
    .stack_pointer, .mem_addr, .mem_wdata, .mem_we, .mem_re, .irq_ack);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task give_verdict;
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // stack ram: writes land at the edge, read data is sampled two edges after the request, one later than a sync ram
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    // vector bytes reload while reset is held
    if (!rst_b) begin
      mem[16'hFFFE] <= 8'h12;
      mem[16'hFFFF] <= 8'h34;
    end
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
      wrs++;
    end
    if (irq_ack) acks++;
  end
  // outside the data cycle the line flips so stale data never looks valid
  always @(negedge sys_clk) begin
    mem_rdata <= re_d ? mem[addr_d] : ~mem_rdata;
    re_d <= mem_re;
    addr_d <= mem_addr;
  end
  task chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
  endtask
  // leaves at least one idle cycle after each op (two after a single-cycle op) so a pending interrupt can get in
  task op(input logic [4:0] c, input logic [7:0] d, input logic [15:0] a);
    wait_idle;
    op_valid = 1'b1;
    op_code = c;
    op_data = d;
    op_addr = a;
    @(negedge sys_clk);
    op_valid = 1'b0;
    @(negedge sys_clk);
    wait_idle;
    // one more cycle so the ram has taken the last stacked byte
    @(negedge sys_clk);
  endtask
  task pulse_irq;
    @(negedge sys_clk);
    irq_req = 1'b1;
    @(negedge sys_clk);
    irq_req = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task t_reset;
    chk(pc, 16'h1234);
    chk(stack_pointer, 16'h017F);
    chk(condition_flags[7:3], 5'h1D);
    @(negedge sys_clk);
  endtask
  task t_flags;
    logic [31:0] r [16];
    r = '{{`CRS_OP_LD_A, 8'h0F, 3'h0, 8'h0F, 8'hE8},
      {`CRS_OP_ADD, 8'h01, 3'h0, 8'h10, 8'hF8}, {`CRS_OP_ADD, 8'hF0, 3'h0, 8'h00, 8'hEB},
      {`CRS_OP_SUB, 8'h01, 3'h0, 8'hFF, 8'hED}, {`CRS_OP_RCF, 8'h00, 3'h0, 8'hFF, 8'hEC},
      {`CRS_OP_SCF, 8'h00, 3'h0, 8'hFF, 8'hED}, {`CRS_OP_LD_A, 8'h00, 3'h0, 8'h00, 8'hEB},
      {`CRS_OP_ADC, 8'h0F, 3'h0, 8'h10, 8'hF8}, {`CRS_OP_BTJ, 8'h04, 3'h2, 8'h10, 8'hF9},
      {`CRS_OP_AND, 8'h0F, 3'h0, 8'h00, 8'hFB}, {`CRS_OP_LD_A, 8'h81, 3'h0, 8'h81, 8'hFD},
      {`CRS_OP_RCF, 8'h00, 3'h0, 8'h81, 8'hFC}, {`CRS_OP_SHL, 8'h00, 3'h0, 8'h02, 8'hF9},
      {`CRS_OP_RLC, 8'h00, 3'h0, 8'h05, 8'hF8}, {`CRS_OP_LD_A, 8'h10, 3'h0, 8'h10, 8'hF8},
      {`CRS_OP_SCF, 8'h00, 3'h0, 8'h10, 8'hF9}};
    foreach (r[i]) begin
      op_bit = r[i][18:16];
      op(r[i][31:27], r[i][26:19], 16'h0000);
      chk(acc, r[i][15:8]);
      chk(condition_flags, r[i][7:0]);
    end
  endtask
  task t_stack;
    op(`CRS_OP_LD_X, 8'h33, 16'h0000);
    op(`CRS_OP_LD_Y, 8'h77, 16'h0000);
    op(`CRS_OP_PUSH_A, 8'h00, 16'h0000);
    op(`CRS_OP_PUSH_CC, 8'h00, 16'h0000);
    chk({mem[16'h017F], mem[16'h017E]}, 16'h10F9);
    chk(stack_pointer, 16'h017D);
    op(`CRS_OP_LD_A, 8'h00, 16'h0000);
    op(`CRS_OP_POP_CC, 8'h00, 16'h0000);
    chk(condition_flags, 8'hF9);
    op(`CRS_OP_POP_A, 8'h00, 16'h0000);
    chk({acc, stack_pointer}, 24'h10017F);
  endtask
  task t_wrap;
    op(`CRS_OP_LD_S, 8'h00, 16'h0000);
    chk(stack_pointer, 16'h0140);
    op(`CRS_OP_PUSH_A, 8'h00, 16'h0000);
    chk({mem[16'h0140], stack_pointer}, 24'h10017F);
    op(`CRS_OP_POP_A, 8'h00, 16'h0000);
    chk({acc, stack_pointer}, 24'h100140);
    op(`CRS_OP_LD_S, 8'hFF, 16'h0000);
    chk(stack_pointer, 16'h017F);
    op(`CRS_OP_LD_S, 8'h05, 16'h0000);
    op(`CRS_OP_RSP, 8'h00, 16'h0000);
    chk(stack_pointer, 16'h017F);
  endtask
  task t_call;
    op(`CRS_OP_JUMP, 8'h00, 16'h2300);
    op(`CRS_OP_PC_ADV, 8'h45, 16'h0000);
    chk(pc, 16'h2345);
    n = wrs;
    op(`CRS_OP_CALL, 8'h00, 16'h5000);
    chk(16'(wrs - n), 16'h0002);
    chk({mem[16'h017F], mem[16'h017E]}, 16'h4523);
    chk(pc, 16'h5000);
    op(`CRS_OP_RET, 8'h00, 16'h0000);
    chk({pc, stack_pointer}, 32'h2345017F);
  endtask
  task t_irq;
    op(`CRS_OP_LD_A, 8'h0F, 16'h0000);
    op(`CRS_OP_ADD, 8'h01, 16'h0000);
    pulse_irq;
    chk(16'(acks), 16'h0000);
    n = wrs;
    op(`CRS_OP_RIM, 8'h00, 16'h0000);
    chk(16'(acks), 16'h0001);
    chk(16'(wrs - n), 16'h0005);
    chk({pc, condition_flags}, 24'h4000F8);
    chk({mem[16'h017F], mem[16'h017E], mem[16'h017D]}, 24'h452333);
    chk({mem[16'h017C], mem[16'h017B], stack_pointer}, 32'h10F0017A);
    pulse_irq;
    chk(16'(acks), 16'h0001);
    op(`CRS_OP_RIM, 8'h00, 16'h0000);
    chk(16'(acks), 16'h0002);
    chk(stack_pointer, 16'h0175);
    op(`CRS_OP_RETURN_FROM_INTERRUPT, 8'h00, 16'h0000);
    chk({pc, condition_flags}, 24'h4000F0);
    op(`CRS_OP_RETURN_FROM_INTERRUPT, 8'h00, 16'h0000);
    chk({pc, stack_pointer}, 32'h2345017F);
    chk({acc, idx_x, idx_y}, 24'h103377);
    op(`CRS_OP_SIM, 8'h00, 16'h0000);
    n = wrs;
    op(`CRS_OP_TRAP, 8'h00, 16'h3000);
    chk({pc, 16'(wrs - n), 16'(acks)}, 48'h300000050002);
  endtask
  initial begin
    rst_b = 1'b0;
    op_valid = 1'b0;
    op_code = 5'h00;
    op_data = 8'h00;
    op_bit = 3'h0;
    op_addr = 16'h0000;
    irq_req = 1'b0;
    irq_vector = 16'h4000;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    wait_idle;
    fork
      begin
        t_reset;
        t_flags;
        t_stack;
        t_wrap;
        t_call;
        t_irq;
      end
      begin
        // a hang ends here as a counted mismatch
        wait (cyc == 3000);
        fail_count++;
      end
    join_any
    give_verdict;
  end
endmodule
`default_nettype wire
